/* File: dv/slc_ctrl_asserts.sv */
// checker: port-level relations of the line-mode control block
`timescale 1ns/100ps
module slc_ctrl_chk
  import slc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        master_reset_pin,
  input wire logic        clk_fail,
  input wire logic        ring_zero_cross,
  input wire logic        test_active,
  input wire slc_mode_t   kit_mode,
  input wire slc_hv_t     hv_ctrl,
  input wire logic        power_denial_oe,
  input wire logic        du_oe,
  input wire logic        digital_output_one,
  input wire logic [7:0]  b1_up,
  input wire slc_path_t   path,
  input wire logic        dsp_reset,
  input wire logic        ring_gen_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_unmapped;
    psel && penable && paddr > 8'h24 |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

  property p_rst_pins;
    !du_oe |-> hv_ctrl == {LV_HIGH, LV_HIGH} && !power_denial_oe && !digital_output_one;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pin states wrong in reset");

  property p_rst_mode;
    !du_oe ##1 !du_oe |-> kit_mode == MD_EXT_IND;
  endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("kit not in external indication");

  property p_mr_take;
    master_reset_pin [*8] |-> ##[0:4] !du_oe;
  endproperty
  a_mr_take: assert property (p_mr_take) else $error("long reset pin level not taken");

  property p_soft;
    psel && penable && pwrite && paddr == ADDR_STATUS_OP && pwdata[SO_RST] |-> ##[1:4] !du_oe;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset not taken");

  property p_lb2;
    path.dsd_to_dec |-> path.rx_to_line && !path.tx_from_line;
  endproperty
  a_lb2: assert property (p_lb2) else $error("digital loop paths wrong");

  property p_lb3;
    path.asd_to_afe |-> !path.rx_to_line && !path.tx_from_line;
  endproperty
  a_lb3: assert property (p_lb3) else $error("analog loop paths wrong");

  property p_cf;
    $rose(clk_fail) |=> dsp_reset;
  endproperty
  a_cf: assert property (p_cf) else $error("clock fail did not reset dsp");

  property p_idle;
    dsp_reset && kit_mode == MD_ACTIVE && !test_active ##1 dsp_reset |-> b1_up inside {IDLE_A_LAW, IDLE_MU_LAW};
  endproperty
  a_idle: assert property (p_idle) else $error("upstream voice not idle");

  property p_ring;
    du_oe && $past(du_oe) && $changed(ring_gen_on) |-> $past(ring_zero_cross);
  endproperty
  a_ring: assert property (p_ring) else $error("ring switched off zero phase");
endmodule : slc_ctrl_chk

bind slc_ctrl slc_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .master_reset_pin(master_reset_pin),
  .clk_fail(clk_fail), .ring_zero_cross(ring_zero_cross), .test_active(test_active), .kit_mode(kit_mode),
  .hv_ctrl(hv_ctrl), .power_denial_oe(power_denial_oe), .du_oe(du_oe), .digital_output_one(digital_output_one),
  .b1_up(b1_up), .path(path), .dsp_reset(dsp_reset), .ring_gen_on(ring_gen_on));

/* File: dv/slc_gci_host.sv */
// line-card controller model: frame ticks and the downstream command byte
`timescale 1ns/100ps
module slc_gci_host #(
  parameter int unsigned FR = 8
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] cmd,
  output logic            frame_tick,
  output logic [7:0]      ci_down
);
  logic [7:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q      <= 8'h00;
      frame_tick <= 1'b0;
    end else begin
      cnt_q      <= (cnt_q == 8'(FR - 1)) ? 8'h00 : cnt_q + 8'h01;
      frame_tick <= (cnt_q == 8'(FR - 1));
    end
  end

  // byte only moves at a frame start, so each request repeats in the next frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ci_down <= 8'h00;
    end else if (cnt_q == 8'h00) begin
      ci_down <= cmd;
    end
  end
endmodule : slc_gci_host

/* File: dv/test_slc_ctrl.sv */
// self-checking bench for the line-mode control block
`timescale 1ns/100ps
module test_slc_ctrl;
  import slc_pkg::*;
  localparam int unsigned FR = 8;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, voice_down_block;
  logic master_reset_pin = 1'b0, clk_fail = 1'b0, ring_zero_cross = 1'b0, ring_period_tick = 1'b0;
  logic meter_half_tick = 1'b0, test_active = 1'b0, test_done = 1'b0, pready, pslverr, frame_tick, meter_on;
  logic [7:0] paddr = 8'h00, b1_down = 8'h00, transversal_current = 8'h00, test_data = 8'h00;
  logic [7:0] cmd = 8'h00, ci_down, ci_up, b1_up, meter_level, tone_800_level;
  logic [3:0] test_pass = 4'h0;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic power_denial_oe, du_oe, digital_output_one, dsp_reset, ring_gen_on, meter_16k, tone_1k_on, tone_800_on;
  logic [16:0] feed_current_ua;
  logic [9:0] feed_res_ohm;
  logic [14:0] drop_mv;
  slc_mode_t kit_mode;
  slc_hv_t hv_ctrl;
  slc_path_t path;
  int num_errors = 0, compares = 0, cycles = 0;

  slc_gci_host #(.FR(FR)) host_u (.pclk(pclk), .presetn(presetn), .cmd(cmd), .frame_tick(frame_tick),
    .ci_down(ci_down));
  slc_ctrl #(.CYC_MS(10), .FREEZE_CY(20)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .master_reset_pin(master_reset_pin), .frame_tick(frame_tick), .ci_down(ci_down),
    .b1_down(b1_down), .b1_voice_up(8'h3C), .clk_fail(clk_fail), .ring_zero_cross(ring_zero_cross),
    .ring_sync_pin(ring_zero_cross),
    .ring_period_tick(ring_period_tick), .transversal_current(transversal_current),
    .meter_half_tick(meter_half_tick), .test_active(test_active), .test_data(test_data),
    .test_done(test_done), .test_pass(test_pass), .kit_mode(kit_mode), .hv_ctrl(hv_ctrl),
    .power_denial_output(), .power_denial_oe(power_denial_oe), .du_oe(du_oe),
    .digital_output_one(digital_output_one), .ci_up(ci_up), .b1_up(b1_up), .path(path),
    .voice_down_block(voice_down_block), .dsp_reset(dsp_reset), .feed_current_ua(feed_current_ua),
    .feed_res_ohm(feed_res_ohm), .drop_mv(drop_mv), .ring_gen_on(ring_gen_on), .meter_on(meter_on),
    .meter_16k(meter_16k), .meter_level(meter_level), .tone_1k_on(tone_1k_on), .tone_800_on(tone_800_on),
    .tone_800_level(tone_800_level));

  task automatic report_and_stop();
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rd_chk

  task automatic tick(input int k);
    @(posedge pclk);
    case (k)
      0: ring_zero_cross <= 1'b1;
      1: ring_period_tick <= 1'b1;
      2: meter_half_tick <= 1'b1;
      default: test_done <= 1'b1;
    endcase
    @(posedge pclk);
    {ring_zero_cross, ring_period_tick, meter_half_tick, test_done} <= 4'h0;
  endtask : tick

  always #10 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    cyc(10);
    presetn <= 1'b1;
    cyc(2);
    chk(kit_mode, MD_EXT_IND);
    chk(power_denial_oe, 1'b0);
    chk(drop_mv, 32'h0000_6E28);
    chk(feed_current_ua, 32'h0000_55F0);
    chk(feed_res_ohm, 32'h0000_0064);
    rd_chk(ADDR_STATUS_OP, 32'h0000_0010);
    apb(1'b0, 8'h28, 32'h0000_0000);
    chk({err, rd}, 33'h1_0000_0000);
    apb(1'b1, ADDR_FEED_CUR, 32'h0000_003F);
    apb(1'b1, ADDR_FEED_RES, 32'h0000_0007);
    apb(1'b1, ADDR_DROP_LVL, 32'h0000_0001);
    cyc(1);
    chk(feed_current_ua, 32'h0001_0EB4);
    chk(feed_res_ohm, 32'h0000_0320);
    chk(drop_mv, 32'h0000_2580);
    b1_down <= 8'h5A;
    for (int s = 1; s < 4; s++) begin
      apb(1'b1, ADDR_LOOP_SEL, 32'(s << 1));
      apb(1'b1, ADDR_MODE_CFG, 32'h0000_0020);
      cyc(2 * FR);
      chk(path.rx_to_line, 1'b0 + (s == 2));
      if (s == 1) chk({kit_mode, b1_up}, {MD_EXT_IND, 8'h5A});
      else chk({kit_mode, path}, {MD_ACTIVE, (s == 2) ? 4'b1010 : 4'b0001});
      apb(1'b1, ADDR_MODE_CFG, 32'h0000_0000);
      cyc(2 * FR);
      chk(path.dsd_to_dec | path.asd_to_afe, 1'b0);
    end
    cmd <= 8'h60;
    cyc(4 * FR);
    chk(kit_mode, MD_ACTIVE);
    apb(1'b1, ADDR_MODE_CFG, 32'h0000_0010);
    apb(1'b1, ADDR_TEST_SEL, {24'h0, TEST_TONE_800});
    cyc(1);
    chk({tone_1k_on, tone_800_on, tone_800_level}, 10'h3FF);
    repeat (3) tick(2);
    cyc(2);
    chk({meter_on, meter_16k, meter_level}, 10'h303);
    clk_fail <= 1'b1;
    cyc(3);
    chk({dsp_reset, voice_down_block, b1_up}, {2'b11, IDLE_A_LAW});
    clk_fail <= 1'b0;
    rd_chk(ADDR_FEED_CUR, 32'h0000_003F);
    chk(kit_mode, MD_ACTIVE);
    cyc(2 * FR);
    chk(dsp_reset, 1'b0);
    test_pass <= 4'hA;
    tick(3);
    test_active <= 1'b1;
    test_data <= 8'hC3;
    cyc(2 * FR);
    chk(b1_up, 8'hC3);
    test_active <= 1'b0;
    rd_chk(ADDR_TEST_SEL, 32'h0000_00A4);
    cmd <= 8'hE0;
    cyc(4 * FR);
    chk({kit_mode, ring_gen_on}, {MD_RING_PAU, 1'b0});
    cmd <= 8'hA0;
    cyc(4 * FR);
    tick(0);
    cyc(2);
    chk({kit_mode, ring_gen_on}, {MD_RING, 1'b1});
    transversal_current <= 8'hFF;
    tick(1);
    tick(1);
    for (int i = 0; i < 400 && ci_up[7] !== 1'b1; i++) @(posedge pclk);
    chk(ci_up[7], 1'b1);
    tick(0);
    cyc(2);
    chk({kit_mode, ring_gen_on}, {MD_STANDBY, 1'b0});
    transversal_current <= 8'h00;
    apb(1'b1, ADDR_STATUS_OP, 32'h0000_0010);
    cyc(4);
    rd_chk(ADDR_FEED_CUR, 32'h0000_0014);
    rd_chk(ADDR_STATUS_OP, 32'h0000_0010);
    cmd <= 8'h40;
    cyc(4 * FR);
    master_reset_pin <= 1'b1;
    cyc(3);
    master_reset_pin <= 1'b0;
    cyc(8);
    chk(du_oe, 1'b1);
    master_reset_pin <= 1'b1;
    cyc(12);
    chk({du_oe, hv_ctrl, digital_output_one, power_denial_oe}, {1'b0, LV_HIGH, LV_HIGH, 2'b00});
    chk(kit_mode, MD_EXT_IND);
    master_reset_pin <= 1'b0;
    cyc(4 * FR);
    chk({du_oe, kit_mode}, {1'b1, MD_ACTIVE});
    report_and_stop();
  end
endmodule : test_slc_ctrl

/* File: rtl/slc_ctrl.sv */
// line-kit mode, feed, metering, ring, loopback, test and reset control with an apb register file
`timescale 1ns/100ps
// Notes on behaviour
// - feed current code in 1.1mA steps, 0-69.3mA
// - feed resistance multiplier n from 1 to 8
// - drop is 9.6V plus field times 600mV
// - metering level rises by drop_lvl_q[2:0] steps per half-period
// - metering 12/16 kHz, amplitude 255 steps
// - ci 11 ring, 10 reduced ring; bit5 switches the ring generator on
// - ring starts at zero phase, stops at zero phase or at once on pin or soft reset
// - ring off-hook over two periods, then persistence
// - reduced ring pause puts kit in stand-by
// - test results to B1 and sticky pass bits
// - loopback only while enable bit set
// - loopback one copies B1, line gets nothing
// - loopback two: active, dsd to decimator, tx cut
// - loopback three: active, both paths cut, asd to afe
// - 1kHz tone and 800Hz tone in active
// - pin or soft reset gives external indication, power denial
// - reset pin states: du off, lines high, pdo off
// - reset pin high resets, short spikes filtered
// - status-operation bit 4 resets after command completes
// - clock fail: dsp reset until good frame, idle code in active
// - clock-fail reset keeps configuration and ring state
// - command byte accepted after two identical frames
// - indications frozen 10ms after each mode change
module slc_ctrl
  import slc_pkg::*;
#(
  parameter int unsigned CYC_MS    = CYC_PER_MS,
  parameter int unsigned FREEZE_CY = FREEZE_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        master_reset_pin,
  input  wire logic        frame_tick,
  input  wire logic [7:0]  ci_down,
  input  wire logic [7:0]  b1_down,
  input  wire logic [7:0]  b1_voice_up,
  input  wire logic        clk_fail,
  input  wire logic        ring_zero_cross,
  input  wire logic        ring_sync_pin,
  input  wire logic        ring_period_tick,
  input  wire logic [7:0]  transversal_current,
  input  wire logic        meter_half_tick,
  input  wire logic        test_active,
  input  wire logic [7:0]  test_data,
  input  wire logic        test_done,
  input  wire logic [3:0]  test_pass,
  output slc_mode_t        kit_mode,
  output slc_hv_t          hv_ctrl,
  output logic             power_denial_output,
  output logic             power_denial_oe,
  output logic             du_oe,
  output logic             digital_output_one,
  output logic [7:0]       ci_up,
  output logic [7:0]       b1_up,
  output slc_path_t        path,
  output logic             voice_down_block,
  output logic             dsp_reset,
  output logic [16:0]      feed_current_ua,
  output logic [9:0]       feed_res_ohm,
  output logic [14:0]      drop_mv,
  output logic             ring_gen_on,
  output logic             meter_on,
  output logic             meter_16k,
  output logic [7:0]       meter_level,
  output logic             tone_1k_on,
  output logic             tone_800_on,
  output logic [7:0]       tone_800_level
);
  logic [7:0]  mode_cfg_q, loop_sel_q, test_sel_q, feed_res_q, drop_lvl_q, status_op_q;
  logic [5:0]  feed_cur_q;
  logic [8:0]  meter_cfg_q;
  logic [16:0] ring_cfg_q;
  logic        mr_s1_q, mr_s2_q, rs_s1_q, rs_s2_q, rs_s3_q;
  logic [2:0]  mr_cnt_q;
  logic        mr_rst_q, soft_pend_q, soft_rst_q;
  logic        rst_int;
  logic        wr, rd, hit;
  logic [7:0]  ci_last_q, ci_ok_q;
  slc_mode_t   mode_d, mode_q;
  logic        zc;
  logic        ring_req;
  logic [1:0]  over_cnt_q;
  logic        hook_raw_q, hook_ind_q;
  logic [31:0] pers_cnt_q, freeze_cnt_q;
  logic        fail_q;
  logic        lb_en, lb1, lb2, lb3;

  // apb slave: zero wait states, unmapped addresses answer with pslverr
  assign wr     = psel & penable & pwrite;
  assign rd     = psel & ~pwrite;
  assign pready = 1'b1;

  always_comb begin
    hit = 1'b1;
    case (paddr)
      ADDR_MODE_CFG:  prdata = {24'h00_0000, mode_cfg_q};
      ADDR_LOOP_SEL:  prdata = {24'h00_0000, loop_sel_q};
      ADDR_TEST_SEL:  prdata = {24'h00_0000, test_sel_q};
      ADDR_FEED_RES:  prdata = {24'h00_0000, feed_res_q};
      ADDR_DROP_LVL:  prdata = {24'h00_0000, drop_lvl_q};
      ADDR_STATUS_OP: prdata = {24'h00_0000, status_op_q};
      ADDR_FEED_CUR:  prdata = {26'h000_0000, feed_cur_q};
      ADDR_METER_CFG: prdata = {23'h00_0000, meter_cfg_q};
      ADDR_RING_CFG:  prdata = {15'h0000, ring_cfg_q};
      ADDR_STATUS:    prdata = {8'h00, meter_level, ci_up, 2'b00, fail_q, hook_ind_q, ring_gen_on, mode_q};
      default: begin
        prdata = 32'h0000_0000;
        hit    = 1'b0;
      end
    endcase
    if (!rd) prdata = 32'h0000_0000;
  end
  assign pslverr = psel & penable & ~hit;

  // reset pin: two-flop sync, then must stay high for the filter time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mr_s1_q <= 1'b0;
      mr_s2_q <= 1'b0;
    end else begin
      mr_s1_q <= master_reset_pin;
      mr_s2_q <= mr_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mr_cnt_q <= 3'h0;
      mr_rst_q <= 1'b0;
    end else if (!mr_s2_q) begin
      mr_cnt_q <= 3'h0;
      mr_rst_q <= 1'b0;
    end else if (mr_cnt_q < 3'(MR_FILTER_CYC - 1)) begin
      mr_cnt_q <= mr_cnt_q + 3'h1;
    end else begin
      mr_rst_q <= 1'b1;
    end
  end

  // soft reset fires one cycle after the write completes, so the bus answer is never cut
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_pend_q <= 1'b0;
      soft_rst_q  <= 1'b0;
    end else begin
      soft_pend_q <= wr && paddr == ADDR_STATUS_OP && pwdata[SO_RST];
      soft_rst_q  <= soft_pend_q;
    end
  end
  assign rst_int = mr_rst_q | soft_rst_q;

  // configuration registers; the reset bit reads 1 after any reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_cfg_q  <= RST_MODE_CFG;
      loop_sel_q  <= RST_LOOP_SEL;
      feed_res_q  <= RST_FEED_RES;
      drop_lvl_q  <= RST_DROP_LVL;
      feed_cur_q  <= RST_FEED_CUR;
      meter_cfg_q <= RST_METER_CFG;
      ring_cfg_q  <= RST_RING_CFG;
      status_op_q <= 8'h10;
    end else if (rst_int) begin
      mode_cfg_q  <= RST_MODE_CFG;
      loop_sel_q  <= RST_LOOP_SEL;
      feed_res_q  <= RST_FEED_RES;
      drop_lvl_q  <= RST_DROP_LVL;
      feed_cur_q  <= RST_FEED_CUR;
      meter_cfg_q <= RST_METER_CFG;
      ring_cfg_q  <= RST_RING_CFG;
      status_op_q <= 8'h10;
    end else if (wr) begin
      case (paddr)
        ADDR_MODE_CFG:  mode_cfg_q  <= pwdata[7:0];
        ADDR_LOOP_SEL:  loop_sel_q  <= pwdata[7:0];
        ADDR_FEED_RES:  feed_res_q  <= pwdata[7:0];
        ADDR_DROP_LVL:  drop_lvl_q  <= pwdata[7:0];
        ADDR_STATUS_OP: status_op_q <= pwdata[7:0];
        ADDR_FEED_CUR:  feed_cur_q  <= (pwdata[5:0] > FEED_CODE_MAX) ? FEED_CODE_MAX : pwdata[5:0];
        ADDR_METER_CFG: meter_cfg_q <= pwdata[8:0];
        ADDR_RING_CFG:  ring_cfg_q  <= pwdata[16:0];
        default: ;
      endcase
    end
  end

  // test select: low nibble written by software, high nibble sticky pass bits; a set beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_sel_q <= RST_TEST_SEL;
    end else if (rst_int) begin
      test_sel_q <= RST_TEST_SEL;
    end else begin
      if (wr && paddr == ADDR_TEST_SEL) test_sel_q <= pwdata[7:0];
      if (test_done) test_sel_q[7:4] <= (wr && paddr == ADDR_TEST_SEL ? pwdata[7:4] : test_sel_q[7:4]) | test_pass;
    end
  end

  // command byte validated when seen identical in two consecutive frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ci_last_q <= 8'h00;
      ci_ok_q   <= 8'h00;
    end else if (frame_tick) begin
      ci_last_q <= ci_down;
      if (ci_down == ci_last_q) ci_ok_q <= ci_down;
    end
  end

  // loopback decode
  assign lb_en = mode_cfg_q[MC_LOOP_EN];
  assign lb1   = lb_en && loop_sel_q[2:1] == 2'b01;
  assign lb2   = lb_en && loop_sel_q[2:1] == 2'b10;
  assign lb3   = lb_en && loop_sel_q[2:1] == 2'b11;

  // ring zero phase comes from the external sync when ringing is unbalanced
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_s1_q <= 1'b0;
      rs_s2_q <= 1'b0;
      rs_s3_q <= 1'b0;
    end else begin
      rs_s1_q <= ring_sync_pin;
      rs_s2_q <= rs_s1_q;
      rs_s3_q <= rs_s2_q;
    end
  end
  assign zc = ring_cfg_q[RC_UNBAL] ? (rs_s2_q & ~rs_s3_q) : ring_zero_cross;

  assign ring_req = ci_ok_q[CI_B7] & ci_ok_q[CI_B5] & ~hook_raw_q;

  always_comb begin
    mode_d = MD_EXT_IND;
    case (ci_ok_q[7:5])
      3'b000:  mode_d = !mode_cfg_q[MC_POWER_UP] ? MD_EXT_IND :
                        (mode_cfg_q[MC_WIRE_A] & mode_cfg_q[MC_WIRE_B]) ? MD_GND_STRT : MD_STANDBY;
      3'b001:  mode_d = MD_LOOP_OPN;
      3'b010,
      3'b011:  mode_d = MD_ACTIVE;
      3'b110,
      3'b111:  mode_d = ring_gen_on ? MD_RING : MD_RING_PAU;
      3'b100,
      3'b101:  mode_d = ring_gen_on ? MD_RING : MD_STANDBY;
      default: mode_d = MD_EXT_IND;
    endcase
    if (lb2 || lb3) mode_d = MD_ACTIVE;
  end

  // mode register: reset forces external indication, then the last validated request applies unless loopback two or three forces active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MD_EXT_IND;
    end else if (rst_int) begin
      mode_q <= MD_EXT_IND;
    end else begin
      mode_q <= mode_d;
    end
  end
  assign kit_mode = mode_q;

  // ring generator switches only on a zero crossing or a pin or soft reset, so bursts start at zero phase and stop there unless reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ring_gen_on <= 1'b0;
    end else if (rst_int) begin
      ring_gen_on <= 1'b0;
    end else if (zc) begin
      ring_gen_on <= ring_req;
    end
  end

  // off-hook in ring: mean current above threshold on two consecutive period ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over_cnt_q <= 2'h0;
      hook_raw_q <= 1'b0;
    end else if (!ci_ok_q[CI_B7]) begin
      over_cnt_q <= 2'h0;
      hook_raw_q <= 1'b0;
    end else if (ring_period_tick) begin
      if (transversal_current > ring_cfg_q[7:0]) begin
        if (over_cnt_q == 2'h1) hook_raw_q <= 1'b1;
        if (over_cnt_q != 2'h2) over_cnt_q <= over_cnt_q + 2'h1;
      end else begin
        over_cnt_q <= 2'h0;
        hook_raw_q <= 1'b0;
      end
    end
  end

  // persistence in milliseconds, plus a freeze window after every mode change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pers_cnt_q <= 32'h0000_0000;
      hook_ind_q <= 1'b0;
    end else if (hook_raw_q == hook_ind_q) begin
      pers_cnt_q <= 32'h0000_0000;
    end else if (pers_cnt_q < 32'(ring_cfg_q[15:8]) * 32'(CYC_MS)) begin
      pers_cnt_q <= pers_cnt_q + 32'h0000_0001;
    end else if (freeze_cnt_q == 32'h0000_0000) begin
      hook_ind_q <= hook_raw_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freeze_cnt_q <= 32'h0000_0000;
    end else if (mode_d != mode_q) begin
      freeze_cnt_q <= 32'(FREEZE_CY);
    end else if (freeze_cnt_q != 32'h0000_0000) begin
      freeze_cnt_q <= freeze_cnt_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ci_up <= 8'h00;
    end else if (rst_int) begin
      ci_up <= 8'h00;
    end else begin
      ci_up[CIU_OFFHOOK] <= hook_ind_q;
    end
  end

  // clock fail: only the dsp is held, configuration and ring logic are left alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_q <= 1'b0;
    end else if (clk_fail) begin
      fail_q <= 1'b1;
    end else if (frame_tick) begin
      fail_q <= 1'b0;
    end
  end
  assign dsp_reset        = fail_q;
  assign voice_down_block = fail_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b1_up <= 8'h00;
    end else if (lb1) begin
      b1_up <= b1_down;
    end else if (test_active) begin
      b1_up <= test_data;
    end else if (fail_q && mode_q == MD_ACTIVE) begin
      b1_up <= mode_cfg_q[MC_LAW_MU] ? IDLE_MU_LAW : IDLE_A_LAW;
    end else begin
      b1_up <= b1_voice_up;
    end
  end

  always_comb begin
    path.rx_to_line   = (mode_q == MD_ACTIVE || lb2) && !lb1 && !lb3;
    path.tx_from_line = mode_q == MD_ACTIVE && !lb2 && !lb3;
    path.dsd_to_dec   = lb2;
    path.asd_to_afe   = lb3;
  end

  // line driver control levels and power denial; pins rest as required while reset is held
  always_comb begin
    hv_ctrl = '{line_a: LV_HIGH, line_b: LV_HIGH};
    case (mode_q)
      MD_ACTIVE:   hv_ctrl = '{line_a: LV_HIGH, line_b: LV_MID};
      MD_RING:     hv_ctrl = '{line_a: LV_LOW, line_b: LV_MID};
      MD_GND_STRT: hv_ctrl = '{line_a: LV_MID, line_b: LV_HIGH};
      MD_LOOP_OPN: hv_ctrl = '{line_a: LV_LOW, line_b: LV_LOW};
      default:     hv_ctrl = '{line_a: LV_HIGH, line_b: LV_HIGH};
    endcase
    if (rst_int) hv_ctrl = '{line_a: LV_HIGH, line_b: LV_HIGH};
  end
  assign power_denial_output = 1'b0;
  assign power_denial_oe     = !rst_int && mode_q != MD_EXT_IND && mode_q != MD_LOOP_OPN;
  assign du_oe               = !rst_int;
  assign digital_output_one  = !rst_int && ring_gen_on && ring_cfg_q[RC_UNBAL];

  // dc feed settings
  assign feed_current_ua = 17'(feed_cur_q) * FEED_UA_STEP;
  assign feed_res_ohm    = 10'({1'b0, feed_res_q[2:0]} + 4'h1) * 10'(RES_OHM_STEP);
  assign drop_mv         = 15'(DROP_BASE_MV) + 15'(drop_lvl_q[7:3]) * 15'(DROP_STEP_MV);

  // metering: the level climbs by drop_lvl_q[2:0] per half period toward the programmed amplitude
  assign meter_on  = mode_q == MD_ACTIVE && ci_ok_q[CI_B5] && !lb_en;
  assign meter_16k = meter_cfg_q[8];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meter_level <= 8'h00;
    end else if (!meter_on) begin
      meter_level <= 8'h00;
    end else if (meter_half_tick) begin
      if ({1'b0, meter_level} + {6'h00, drop_lvl_q[2:0]} >= {1'b0, meter_cfg_q[7:0]}) begin
        meter_level <= meter_cfg_q[7:0];
      end else begin
        meter_level <= meter_level + {5'h00, drop_lvl_q[2:0]};
      end
    end
  end

  // test tones only in active mode; both may run together
  assign tone_1k_on     = mode_q == MD_ACTIVE && mode_cfg_q[MC_TONE_EN];
  assign tone_800_on    = mode_q == MD_ACTIVE && {4'h0, test_sel_q[3:0]} == TEST_TONE_800;
  assign tone_800_level = meter_cfg_q[7:0];
endmodule : slc_ctrl

/* File: rtl/slc_pkg.sv */
// package: register map, field layout, reset values and timing for the line-mode control block
package slc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MR_FILTER_NS  = 90;
  localparam int unsigned MR_FILTER_CYC = (MR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned FREEZE_MS     = 10;
  localparam int unsigned FREEZE_CYC    = FREEZE_MS * CYC_PER_MS;

  localparam logic [7:0] ADDR_MODE_CFG   = 8'h00;
  localparam logic [7:0] ADDR_LOOP_SEL   = 8'h04;
  localparam logic [7:0] ADDR_TEST_SEL   = 8'h08;
  localparam logic [7:0] ADDR_FEED_RES   = 8'h0C;
  localparam logic [7:0] ADDR_DROP_LVL   = 8'h10;
  localparam logic [7:0] ADDR_STATUS_OP  = 8'h14;
  localparam logic [7:0] ADDR_FEED_CUR   = 8'h18;
  localparam logic [7:0] ADDR_METER_CFG  = 8'h1C;
  localparam logic [7:0] ADDR_RING_CFG   = 8'h20;
  localparam logic [7:0] ADDR_STATUS     = 8'h24;

  // mode_config_reg fields
  localparam int unsigned MC_LAW_MU   = 0;
  localparam int unsigned MC_WIRE_B   = 2;
  localparam int unsigned MC_WIRE_A   = 3;
  localparam int unsigned MC_TONE_EN  = 4;
  localparam int unsigned MC_LOOP_EN  = 5;
  localparam int unsigned MC_POWER_UP = 7;
  // status_operation_command
  localparam int unsigned SO_RST      = 4;
  // command/indicate byte
  localparam int unsigned CI_B5       = 5;
  localparam int unsigned CI_B6       = 6;
  localparam int unsigned CI_B7       = 7;
  localparam int unsigned CIU_OFFHOOK = 7;
  // ring_cfg fields
  localparam int unsigned RC_UNBAL    = 16;

  localparam logic [7:0]  RST_MODE_CFG  = 8'h00;
  localparam logic [7:0]  RST_LOOP_SEL  = 8'h00;
  localparam logic [7:0]  RST_TEST_SEL  = 8'h00;
  localparam logic [7:0]  RST_FEED_RES  = 8'h00;
  localparam logic [7:0]  RST_DROP_LVL  = 8'hF9;
  localparam logic [5:0]  RST_FEED_CUR  = 6'h14;
  localparam logic [8:0]  RST_METER_CFG = 9'h1FF;
  localparam logic [16:0] RST_RING_CFG  = 17'h0_0A10;
  localparam logic [5:0]  FEED_CODE_MAX = 6'h3F;
  localparam logic [7:0]  TEST_TONE_800 = 8'h04;
  localparam logic [7:0]  IDLE_A_LAW    = 8'hD5;
  localparam logic [7:0]  IDLE_MU_LAW   = 8'hFF;
  localparam logic [16:0] FEED_UA_STEP  = 17'h0_044C;
  localparam logic [6:0]  RES_OHM_STEP  = 7'h64;
  localparam logic [13:0] DROP_BASE_MV  = 14'h2580;
  localparam logic [13:0] DROP_STEP_MV  = 14'h0258;

  typedef enum logic [1:0] {
    LV_LOW  = 2'b00,
    LV_MID  = 2'b01,
    LV_HIGH = 2'b10
  } slc_level_t;

  typedef enum logic [2:0] {
    MD_EXT_IND  = 3'b000,
    MD_LOOP_OPN = 3'b001,
    MD_STANDBY  = 3'b010,
    MD_GND_STRT = 3'b011,
    MD_ACTIVE   = 3'b100,
    MD_RING     = 3'b101,
    MD_RING_PAU = 3'b110
  } slc_mode_t;

  typedef struct packed {
    slc_level_t line_a;
    slc_level_t line_b;
  } slc_hv_t;

  typedef struct packed {
    logic rx_to_line;
    logic tx_from_line;
    logic dsd_to_dec;
    logic asd_to_afe;
  } slc_path_t;
endpackage : slc_pkg
